// file: design/scpist_regs.svh
/*
 * constants of the status register groups: register selects, bit positions,
 * reset values and widths.
 * assumes it is included by its bare name before the package and the modules.
 */
`ifndef SCPIST_REGS_SVH
`define SCPIST_REGS_SVH

// register selects carried by a status command
`define SCPIST_SEL_COND    3'h0
`define SCPIST_SEL_PTR     3'h1
`define SCPIST_SEL_NTR     3'h2
`define SCPIST_SEL_EVT     3'h3
`define SCPIST_SEL_ENA     3'h4

// group selects
`define SCPIST_GRP_QUES    1'h0
`define SCPIST_GRP_CALL    1'h1

// register width and bit positions
`define SCPIST_WIDTH       16
`define SCPIST_BIT_ZERO    15
`define SCPIST_QUES_CAL    8
`define SCPIST_CALL_CONN   5
`define SCPIST_CALL_ACC    4
`define SCPIST_CALL_PAGE   3
`define SCPIST_CALL_REG    1
`define SCPIST_CALL_ACT    0

// condition bits that can ever be one
`define SCPIST_QUES_MASK   16'h0100
`define SCPIST_CALL_MASK   16'h003b

// reset values
`define SCPIST_PTR_RST     16'hffff
`define SCPIST_NTR_RST     16'h0000
`define SCPIST_EVT_RST     16'h0000
`define SCPIST_ENA_RST     16'h0000

`endif

// file: design/scpist_pkg.sv
/*
 * types shared by the status register groups.
 * assumes scpist_regs.svh is compiled first.
 */
`include "scpist_regs.svh"

package scpist_pkg;

  typedef logic [`SCPIST_WIDTH-1:0] scpist_word_t;

  typedef enum logic [2:0] {
    SCPIST_COND = `SCPIST_SEL_COND,
    SCPIST_PTR  = `SCPIST_SEL_PTR,
    SCPIST_NTR  = `SCPIST_SEL_NTR,
    SCPIST_EVT  = `SCPIST_SEL_EVT,
    SCPIST_ENA  = `SCPIST_SEL_ENA
  } scpist_sel_t;

  typedef struct packed {
    scpist_word_t prev;
    scpist_word_t ptr;
    scpist_word_t ntr;
    scpist_word_t evt;
    scpist_word_t ena;
  } scpist_grp_state_t;

  typedef struct packed {
    logic         resp_valid;
    scpist_word_t resp_data;
    logic         ques_summ;
    logic         call_summ;
  } scpist_top_state_t;

endpackage

// file: design/scpist_grp_if.sv
/*
 * link between the command decoder and one status register group.
 * assumes one clock domain; strobes are one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none

interface scpist_grp_if;
  scpist_pkg::scpist_word_t cond;
  logic                     wr;
  scpist_pkg::scpist_sel_t  sel;
  scpist_pkg::scpist_word_t wdata;
  logic                     rd_evt;
  logic                     cls;
  scpist_pkg::scpist_word_t ptr;
  scpist_pkg::scpist_word_t ntr;
  scpist_pkg::scpist_word_t evt;
  scpist_pkg::scpist_word_t ena;
  logic                     summ;

  modport ctl (output cond, wr, sel, wdata, rd_evt, cls,
               input  ptr, ntr, evt, ena, summ);
  modport grp (input  cond, wr, sel, wdata, rd_evt, cls,
               output ptr, ntr, evt, ena, summ);
endinterface

`default_nettype wire

// file: design/scpist_group.sv
/*
 * one status register group: transition filters, latched event register,
 * enable register and summary.
 * assumes the condition word arrives on the same clock with unused bits zero.
 */
`timescale 1ns/100ps
`default_nettype none
`include "scpist_regs.svh"

module scpist_group (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    srst,
  // decoder side
  scpist_grp_if.grp    bus
);

  scpist_pkg::scpist_grp_state_t st_r;
  scpist_pkg::scpist_grp_state_t st_nxt;
  scpist_pkg::scpist_word_t      hit;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = bus.cond;
    hit = (bus.cond & ~st_r.prev & st_r.ptr) | (~bus.cond & st_r.prev & st_r.ntr);
    // a new event in the clearing cycle survives the clear
    if (bus.rd_evt || bus.cls) begin
      st_nxt.evt = hit;
    end else begin
      st_nxt.evt = st_r.evt | hit;
    end
    if (bus.wr) begin
      unique case (bus.sel)
        scpist_pkg::SCPIST_PTR: st_nxt.ptr = bus.wdata;
        scpist_pkg::SCPIST_NTR: st_nxt.ntr = bus.wdata;
        scpist_pkg::SCPIST_ENA: st_nxt.ena = bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.prev <= 16'h0000;
      st_r.ptr  <= `SCPIST_PTR_RST;
      st_r.ntr  <= `SCPIST_NTR_RST;
      st_r.evt  <= `SCPIST_EVT_RST;
      st_r.ena  <= `SCPIST_ENA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.ptr  = st_r.ptr;
  assign bus.ntr  = st_r.ntr;
  assign bus.evt  = st_r.evt;
  assign bus.ena  = st_r.ena;
  assign bus.summ = |(st_r.evt & st_r.ena);

  ////////////////////////////////////////////////////////////////////////////

  property p_rise_latch;
    @(posedge clk) disable iff (srst)
      (bus.cond[0] && !st_r.prev[0] && st_r.ptr[0]) |=> bus.evt[0];
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("rise not latched");

  property p_fall_latch;
    @(posedge clk) disable iff (srst)
      (!bus.cond[0] && st_r.prev[0] && st_r.ntr[0]) |=> bus.evt[0];
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("fall not latched");

  property p_clear;
    @(posedge clk) disable iff (srst)
      ((bus.rd_evt || bus.cls) && hit == 16'h0000) |=> bus.evt == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("event not cleared");

  property p_hold;
    @(posedge clk) disable iff (srst)
      !(bus.rd_evt || bus.cls) |=> ((bus.evt & $past(bus.evt)) == $past(bus.evt));
  endproperty
  a_hold: assert property (p_hold) else $error("event bit lost");

  // a fresh enabled edge must show in the summary even if a clear lands with it
  property p_summ;
    @(posedge clk) disable iff (srst)
      ((|(hit & st_r.ena)) && !(bus.wr && bus.sel == scpist_pkg::SCPIST_ENA)) |=> bus.summ;
  endproperty
  a_summ: assert property (p_summ) else $error("summary wrong");

  property p_ena_wr;
    @(posedge clk) disable iff (srst)
      (bus.wr && bus.sel == scpist_pkg::SCPIST_ENA) |=> bus.ena == $past(bus.wdata);
  endproperty
  a_ena_wr: assert property (p_ena_wr) else $error("enable not stored");

  property p_ptr_wr;
    @(posedge clk) disable iff (srst)
      (bus.wr && bus.sel == scpist_pkg::SCPIST_PTR) |=> bus.ptr == $past(bus.wdata);
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("filter not stored");

  c_latch: cover property (@(posedge clk) disable iff (srst) bus.summ ##1 bus.rd_evt);
  c_cls: cover property (@(posedge clk) disable iff (srst) bus.cls && bus.evt != 16'h0000);

endmodule

`default_nettype wire

// file: design/scpist_top.sv
/*
 * questionable data/signal and call processing status register groups with
 * their status command port.
 * assumes commands and status inputs come from logic on the same clock.
 */
// How it works
// - questionable group: sixteen-bit condition, filters, event, enable
// - questionable condition reports output data quality
// - call processing group has same register set
// - condition bit fifteen always reads zero
// - questionable bit eight is calibration summary
// - summary follows enabled latched event one cycle late
// - event cleared by query or clear-status
// - condition query returns current condition
// - both transition filters readable separately
// - filter write command stores the pattern
// - enable write stores, enable query returns it
// - call bits: connect5 access4 page3 reg1 act0
// - call bit follows its front-panel indicator
`timescale 1ns/100ps
`default_nettype none
`include "scpist_regs.svh"

module scpist_top (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // status command port
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_group,
  input  wire scpist_pkg::scpist_sel_t  cmd_sel,
  input  wire logic                     cmd_write,
  input  wire scpist_pkg::scpist_word_t cmd_data,
  input  wire logic                     cls,
  output logic                          resp_valid,
  output scpist_pkg::scpist_word_t      resp_data,
  // status sources
  input  wire logic                     cal_summary,
  input  wire logic                     led_connect,
  input  wire logic                     led_access,
  input  wire logic                     led_page,
  input  wire logic                     led_register,
  input  wire logic                     led_active,
  // group summaries
  output logic                          ques_summary,
  output logic                          call_summary
);

  scpist_grp_if ques_if ();
  scpist_grp_if call_if ();

  scpist_pkg::scpist_top_state_t st_r;
  scpist_pkg::scpist_top_state_t st_nxt;
  scpist_pkg::scpist_word_t      questionable_condition;
  scpist_pkg::scpist_word_t      call_cond;
  logic                          sel_ques;
  logic                          sel_call;
  logic                          is_read;

  ////////////////////////////////////////////////////////////////////////////
  // condition words

  always_comb begin
    questionable_condition = 16'h0000;
    questionable_condition[`SCPIST_QUES_CAL] = cal_summary;
    questionable_condition = questionable_condition & `SCPIST_QUES_MASK;
    call_cond = 16'h0000;
    call_cond[`SCPIST_CALL_CONN] = led_connect;
    call_cond[`SCPIST_CALL_ACC]  = led_access;
    call_cond[`SCPIST_CALL_PAGE] = led_page;
    call_cond[`SCPIST_CALL_REG]  = led_register;
    call_cond[`SCPIST_CALL_ACT]  = led_active;
    call_cond = call_cond & `SCPIST_CALL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  assign sel_ques = cmd_valid && (cmd_group == `SCPIST_GRP_QUES);
  assign sel_call = cmd_valid && (cmd_group == `SCPIST_GRP_CALL);
  assign is_read  = cmd_valid && !cmd_write;

  assign ques_if.cond   = questionable_condition;
  assign ques_if.wr     = sel_ques && cmd_write;
  assign ques_if.sel    = cmd_sel;
  assign ques_if.wdata  = cmd_data;
  assign ques_if.rd_evt = sel_ques && !cmd_write && cmd_sel == scpist_pkg::SCPIST_EVT;
  assign ques_if.cls    = cls;

  assign call_if.cond   = call_cond;
  assign call_if.wr     = sel_call && cmd_write;
  assign call_if.sel    = cmd_sel;
  assign call_if.wdata  = cmd_data;
  assign call_if.rd_evt = sel_call && !cmd_write && cmd_sel == scpist_pkg::SCPIST_EVT;
  assign call_if.cls    = cls;

  scpist_group u_ques (
    .clk  (clk),
    .srst (srst),
    .bus  (ques_if.grp)
  );

  scpist_group u_call (
    .clk  (clk),
    .srst (srst),
    .bus  (call_if.grp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // answers and registered outputs

  always_comb begin
    st_nxt            = st_r;
    st_nxt.resp_valid = is_read;
    st_nxt.ques_summ  = ques_if.summ;
    st_nxt.call_summ  = call_if.summ;
    if (is_read) begin
      // the event word is answered as it stood before the clear
      unique case (cmd_sel)
        scpist_pkg::SCPIST_COND:
          st_nxt.resp_data = cmd_group ? call_cond : questionable_condition;
        scpist_pkg::SCPIST_PTR:
          st_nxt.resp_data = cmd_group ? call_if.ptr : ques_if.ptr;
        scpist_pkg::SCPIST_NTR:
          st_nxt.resp_data = cmd_group ? call_if.ntr : ques_if.ntr;
        scpist_pkg::SCPIST_EVT:
          st_nxt.resp_data = cmd_group ? call_if.evt : ques_if.evt;
        scpist_pkg::SCPIST_ENA:
          st_nxt.resp_data = cmd_group ? call_if.ena : ques_if.ena;
        default:
          st_nxt.resp_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign resp_valid   = st_r.resp_valid;
  assign resp_data    = st_r.resp_data;
  assign ques_summary = st_r.ques_summ;
  assign call_summary = st_r.call_summ;

  ////////////////////////////////////////////////////////////////////////////

  property p_resp_timing;
    @(posedge clk) disable iff (srst) is_read |=> resp_valid;
  endproperty
  a_resp_timing: assert property (p_resp_timing) else $error("no answer");

  property p_cond_ques;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_COND && !cmd_group)
        |=> resp_data == {7'h00, $past(cal_summary), 8'h00};
  endproperty
  a_cond_ques: assert property (p_cond_ques) else $error("bad questionable_condition");

  property p_cond_call;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_COND && cmd_group)
        |=> resp_data == {10'h000, $past(led_connect), $past(led_access),
                          $past(led_page), 1'h0, $past(led_register), $past(led_active)};
  endproperty
  a_cond_call: assert property (p_cond_call) else $error("bad call cond");

  property p_bit15;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_COND) |=> !resp_data[`SCPIST_BIT_ZERO];
  endproperty
  a_bit15: assert property (p_bit15) else $error("bit 15 set");

  property p_summ_out;
    @(posedge clk) disable iff (srst) ##1 call_summary == $past(call_if.summ);
  endproperty
  a_summ_out: assert property (p_summ_out) else $error("summary late");

  property p_summ_ques;
    @(posedge clk) disable iff (srst)
      ##1 ques_summary == $past(ques_if.summ);
  endproperty
  a_summ_ques: assert property (p_summ_ques) else $error("ques summary late");

  // a write or an idle cycle must not raise a stale answer
  property p_no_resp;
    @(posedge clk) disable iff (srst)
      !is_read |=> !resp_valid;
  endproperty
  a_no_resp: assert property (p_no_resp) else $error("answer without query");

  property p_hold_data;
    @(posedge clk) disable iff (srst)
      !is_read |=> $stable(resp_data);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("answer word changed");

  // the event answer is the word before the clear, not after it
  property p_evt_ques;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_EVT && !cmd_group)
        |=> resp_data == $past(ques_if.evt);
  endproperty
  a_evt_ques: assert property (p_evt_ques) else $error("bad ques event answer");

  property p_evt_call;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_EVT && cmd_group)
        |=> resp_data == $past(call_if.evt);
  endproperty
  a_evt_call: assert property (p_evt_call) else $error("bad call event answer");

  property p_ptr_call;
    @(posedge clk) disable iff (srst)
      (is_read && cmd_sel == scpist_pkg::SCPIST_PTR && cmd_group)
        |=> resp_data == $past(call_if.ptr);
  endproperty
  a_ptr_call: assert property (p_ptr_call) else $error("bad filter answer");

  c_ques_rd: cover property (@(posedge clk) disable iff (srst) ques_summary ##1 resp_valid);
  c_call_up: cover property (@(posedge clk) disable iff (srst) $rose(call_summary));

endmodule

`default_nettype wire

// file: testbench/scpist_ctl_model.sv
/*
 * remote controller model: drives the status command port of the groups.
 * assumes each call lands just after a rising clock edge, one call per cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module scpist_ctl_model (
  // command port
  output logic                     cmd_valid,
  output logic                     cmd_group,
  output scpist_pkg::scpist_sel_t  cmd_sel,
  output logic                     cmd_write,
  output scpist_pkg::scpist_word_t cmd_data,
  output logic                     cls
);
  // one call per cycle; an idle call should carry junk data so stale words are not trusted
  task automatic put(input logic v, input logic g, input logic [2:0] s, input logic w,
                     input scpist_pkg::scpist_word_t d, input logic c);
    cmd_valid = v;
    cmd_group = g;
    cmd_sel   = scpist_pkg::scpist_sel_t'(s);
    cmd_write = w;
    cmd_data  = d;
    cls       = c;
  endtask

  initial put(1'h0, 1'h0, 3'h0, 1'h0, 16'h0000, 1'h0);
endmodule

`default_nettype wire

// file: testbench/scpi_status_register_groups_tb.sv
/*
 * self-checking bench of the two status register groups, random and directed.
 * assumes the controller model and a cycle model in this file predict the ports.
 */
`timescale 1ns/100ps
`default_nettype none

module scpi_status_register_groups_tb;
  typedef scpist_pkg::scpist_word_t scpist_tbw_t;
  logic        clk     = 1'h0;
  logic        srst    = 1'h1;
  logic [5:0]  stat_in = 6'h00;
  logic        cmd_valid, cmd_group, cmd_write, cls;
  logic        resp_valid, ques_summary, call_summary;
  scpist_pkg::scpist_sel_t cmd_sel;
  scpist_tbw_t cmd_data, resp_data, exp_rd;
  scpist_tbw_t m_prev[2], m_ptr[2], m_ntr[2], m_evt[2], m_ena[2], cnd[2];
  logic        exp_rv, exp_qs, exp_cs;
  logic        chk_on  = 1'h0;
  int          err_total = 0;
  int          checks  = 0;

  always #25 clk = ~clk;

  scpist_top i_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_group(cmd_group),
    .cmd_sel(cmd_sel), .cmd_write(cmd_write), .cmd_data(cmd_data), .cls(cls),
    .resp_valid(resp_valid), .resp_data(resp_data), .cal_summary(stat_in[5]),
    .led_connect(stat_in[4]), .led_access(stat_in[3]), .led_page(stat_in[2]),
    .led_register(stat_in[1]), .led_active(stat_in[0]), .ques_summary(ques_summary),
    .call_summary(call_summary));

  scpist_ctl_model i_ctl (.cmd_valid(cmd_valid), .cmd_group(cmd_group), .cmd_sel(cmd_sel),
    .cmd_write(cmd_write), .cmd_data(cmd_data), .cls(cls));

  ////////////////////////////////////////////////////////////////////////////
  function automatic scpist_tbw_t evt_next(scpist_tbw_t e, scpist_tbw_t c, scpist_tbw_t p,
                                           scpist_tbw_t pt, scpist_tbw_t nt, logic clr);
    // a new edge wins over a clear in the same cycle
    return (clr ? 16'h0000 : e) | (c & ~p & pt) | (~c & p & nt);
  endfunction

  function automatic scpist_tbw_t rd_val(int g, logic [2:0] s);
    case (s)
      3'h0: return cnd[g];
      3'h1: return m_ptr[g];
      3'h2: return m_ntr[g];
      3'h3: return m_evt[g];
      3'h4: return m_ena[g];
      default: return 16'h0000;
    endcase
  endfunction

  always @(posedge clk) begin
    cnd[0] = {7'h00, stat_in[5], 8'h00};
    cnd[1] = {10'h000, stat_in[4:2], 1'h0, stat_in[1:0]};
    if (srst) begin
      for (int g = 0; g < 2; g++) begin
        m_prev[g] = 16'h0000;
        m_ptr[g]  = 16'hffff;
        m_ntr[g]  = 16'h0000;
        m_evt[g]  = 16'h0000;
        m_ena[g]  = 16'h0000;
      end
      exp_rv = 1'h0;
      exp_rd = 16'h0000;
      exp_qs = 1'h0;
      exp_cs = 1'h0;
    end else begin
      exp_qs = |(m_evt[0] & m_ena[0]);
      exp_cs = |(m_evt[1] & m_ena[1]);
      exp_rv = cmd_valid & ~cmd_write;
      if (exp_rv) exp_rd = rd_val(cmd_group, cmd_sel);
      for (int g = 0; g < 2; g++) begin
        m_evt[g] = evt_next(m_evt[g], cnd[g], m_prev[g], m_ptr[g], m_ntr[g],
                            cls | (exp_rv && cmd_group == g && cmd_sel == scpist_pkg::SCPIST_EVT));
        m_prev[g] = cnd[g];
        if (cmd_valid && cmd_write && cmd_group == g) begin
          if (cmd_sel == scpist_pkg::SCPIST_PTR) m_ptr[g] = cmd_data;
          if (cmd_sel == scpist_pkg::SCPIST_NTR) m_ntr[g] = cmd_data;
          if (cmd_sel == scpist_pkg::SCPIST_ENA) m_ena[g] = cmd_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string nm, scpist_tbw_t e, scpist_tbw_t g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  always @(negedge clk) begin
    if (chk_on) begin
      cmp("resp_valid", {15'h0000, exp_rv}, {15'h0000, resp_valid});
      cmp("resp_data", exp_rd, resp_data);
      cmp("ques_summary", {15'h0000, exp_qs}, {15'h0000, ques_summary});
      cmp("call_summary", {15'h0000, exp_cs}, {15'h0000, call_summary});
    end
  end

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(logic v, logic g, logic [2:0] s, logic w, scpist_tbw_t d, logic c);
    i_ctl.put(v, g, s, w, d, c);
    @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(24));
    @(posedge clk);
    #1 chk_on = 1'h1;
    repeat (11) @(posedge clk);
    #1 srst = 1'h0;
    cyc(1'h1, 1'h1, 3'h4, 1'h1, 16'h003b, 1'h0);
    stat_in = 6'h1b;
    cyc(1'h1, 1'h1, 3'h2, 1'h1, 16'hffff, 1'h0);
    stat_in = 6'h00;
    cyc(1'h1, 1'h1, 3'h3, 1'h0, 16'h0000, 1'h0);
    cyc(1'h1, 1'h1, 3'h3, 1'h0, 16'h0000, 1'h0);
    cyc(1'h1, 1'h0, 3'h0, 1'h1, 16'hffff, 1'h0);
    cyc(1'h1, 1'h0, 3'h0, 1'h0, 16'h0000, 1'h1);
    for (int i = 0; i < 3000; i++) begin
      if (i % 4 == 0) stat_in = 6'($urandom);
      srst = (i == 1500 || i == 1501);
      if ($urandom_range(0, 2) == 0)
        cyc(1'h0, cmd_group, cmd_sel, cmd_write, ~cmd_data, $urandom_range(0, 15) == 0);
      else
        cyc(1'h1, 1'($urandom), 3'($urandom_range(0, 7)), 1'($urandom), 16'($urandom),
            $urandom_range(0, 15) == 0);
    end
    // one idle cycle so the answer to the last query is still compared
    cyc(1'h0, cmd_group, cmd_sel, cmd_write, cmd_data, 1'h0);
    @(negedge clk);
    #1 end_of_test();
  end

  // the run needs about 3020 cycles
  initial begin
    #(4000 * 50);
    err_total++;
    end_of_test();
  end
endmodule

`default_nettype wire
